// ===== slsw_regs.svh
// Constants of the serial write port: slot numbers, field positions, reset values, timing.
// Assumes nothing; included by the package and by every design file that needs a figure.
`ifndef SLSW_REGS_SVH
`define SLSW_REGS_SVH

`define SLSW_WORD_BITS       16
`define SLSW_SLOT_HARDSCAN_CONTROL_REG       4'hD
`define SLSW_SLOT_FIFO       4'hE
`define SLSW_SEL_SLOT_MSB    3
`define SLSW_SEL_SLOT_LSB    0
`define SLSW_SEL_CHAS_MSB    7
`define SLSW_SEL_CHAS_LSB    4
`define SLSW_ENTRY_SLOT_MSB  10
`define SLSW_ENTRY_SLOT_LSB  7
`define SLSW_ENTRY_CNT_MSB   6
`define SLSW_ENTRY_CNT_LSB   0
`define SLSW_HARDSCAN_CONTROL_REG_RETRANSMIT 6
`define SLSW_HARDSCAN_CONTROL_REG_RESET_N    3
`define SLSW_HARDSCAN_CONTROL_REG_LOAD_N     2
`define SLSW_HARDSCAN_CONTROL_REG_RESET      8'h4C
`define SLSW_CONFIG_RESET    16'h0000
`define SLSW_SCAN_DEPTH      256
`define SLSW_CLOCK_NS        5
`define SLSW_SERIAL_HALF_NS  80
`define SLSW_SELECT_GAP_NS   80
`define SLSW_HALF_CYCLES     ((`SLSW_SERIAL_HALF_NS + `SLSW_CLOCK_NS - 1) / `SLSW_CLOCK_NS)
`define SLSW_GAP_CYCLES      ((`SLSW_SELECT_GAP_NS + `SLSW_CLOCK_NS - 1) / `SLSW_CLOCK_NS)

`endif

// ===== slsw_pkg.sv
// Types shared by both ends of the serial write port.
// Assumes slsw_regs.svh is on the include path.
`include "slsw_regs.svh"

package slsw_pkg;

  typedef struct packed {
    logic [3:0] slot;
    logic [6:0] count;
  } slsw_entry_s;

  typedef enum {
    SLSW_IDLE,
    SLSW_SETUP,
    SLSW_LOW,
    SLSW_HIGH,
    SLSW_TOGGLE
  } slsw_host_state_e;

  function automatic slsw_entry_s slsw_unpack(input logic [15:0] word);
    slsw_entry_s e;
    e.slot  = word[`SLSW_ENTRY_SLOT_MSB:`SLSW_ENTRY_SLOT_LSB];
    e.count = word[`SLSW_ENTRY_CNT_MSB:`SLSW_ENTRY_CNT_LSB];
    return e;
  endfunction

endpackage

// ===== slsw_if.sv
// Serial lines between the host board and the chassis controller.
// Assumes the host drives every line; the device only listens.
`timescale 1ns/1ps
`default_nettype none

interface slsw_if;
  logic serial_clock;
  logic serial_data_in;
  logic slot0_select_n;
  logic data_addr_n;

  modport host (
    output serial_clock,
    output serial_data_in,
    output slot0_select_n,
    output data_addr_n
  );

  modport device (
    input serial_clock,
    input serial_data_in,
    input slot0_select_n,
    input data_addr_n
  );
endinterface

`default_nettype wire

// ===== slsw_scan_list.sv
// Scan-list queue: appends entries, reads them in a loop, clears and rewinds.
// Assumes all controls come from logic on i_clock.
`timescale 1ns/1ps
`default_nettype none
`include "slsw_regs.svh"

module slsw_scan_list #(
  parameter int DEPTH = `SLSW_SCAN_DEPTH,
  parameter int WIDTH = 11
) (
  // Clock and reset.
  input  wire logic                       i_clock,
  input  wire logic                       i_nrst,
  // Control.
  input  wire logic                       i_clear,
  input  wire logic                       i_rewind,
  input  wire logic                       i_advance,
  // Append port.
  input  wire logic                       i_write,
  input  wire logic [WIDTH-1:0]           i_data,
  // State.
  output logic      [WIDTH-1:0]           o_head,
  output logic      [$clog2(DEPTH+1)-1:0] o_entries,
  output logic                            o_full
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("Scan list depth must be a power of two of at least two.");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic             write_ok;

  assign o_full   = (o_entries == CW'(DEPTH));
  assign write_ok = i_write && !o_full && !i_clear;

  always_ff @(posedge i_clock) begin
    if (write_ok) begin
      mem[wr_ptr] <= i_data;
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      wr_ptr    <= '0;
      o_entries <= '0;
    end else if (i_clear) begin
      wr_ptr    <= '0;
      o_entries <= '0;
    end else if (write_ok) begin
      wr_ptr    <= wr_ptr + AW'(1);
      o_entries <= o_entries + CW'(1);
    end
  end

  // The read position wraps at the last stored entry, so a list replays in a loop.
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      rd_ptr <= '0;
    end else if (i_clear || i_rewind) begin
      rd_ptr <= '0;
    end else if (i_advance && o_entries != '0) begin
      if ({1'b0, rd_ptr} == o_entries - CW'(1)) begin
        rd_ptr <= '0;
      end else begin
        rd_ptr <= rd_ptr + AW'(1);
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_head <= '0;
    end else begin
      o_head <= mem[rd_ptr];
    end
  end
endmodule

`default_nettype wire

// ===== slsw_device.sv
// Chassis controller end: slot-select register, one module, hardscan control and scan list.
// Assumes the host keeps serial_clock still while it moves slot0_select_n.
//
// Function
// - Entry holds slot and sample count.
// - Slot 14 shifts sixteen bits, MSB first.
// - Each entry write appends unless full; 256 deep.
// - Hardscan reset low empties the queue.
// - Bits 10..7 plus one give slot.
// - Bits 6..0 plus one give samples.
// - Host idles select high, clock high.
// - Select low deasserts every module select.
// - Bits sampled on rising clock, MSB first.
// - Select high asserts the shifted slot.
// - Only matching chassis address selects.
// - Host parks slot-select register at zero.
// - Data/address low targets module configuration.
// - Select low latches word, deselects, rearms.
// - Write-only registers, all bits update together.
// - Host writes whole shadow copies.
// - Configuration zero at power-up, backplane reset.
// - Reset state: direct routing, bus off.
// - Retransmit low rewinds read position only.
// - Counter load low loads head entry.
`timescale 1ns/1ps
`default_nettype none
`include "slsw_regs.svh"

module slsw_device #(
  parameter logic [3:0] CHASSIS_ADDR = 4'h0,
  parameter logic [3:0] MODULE_SLOT  = 4'h1,
  parameter int         DEPTH        = `SLSW_SCAN_DEPTH
) (
  // System clock and reset.
  input  wire logic                       i_clock,
  input  wire logic                       i_nrst,
  // Serial link from the host.
  slsw_if.device                          link,
  // Backplane and scan engine.
  input  wire logic                       i_backplane_reset_n,
  input  wire logic                       i_scan_advance,
  // Selection and register contents.
  output logic      [15:0]                o_module_select_n,
  output logic      [15:0]                o_config,
  output logic      [7:0]                 o_hardscan_ctrl,
  // Scan list state.
  output logic      [4:0]                 o_scan_slot,
  output logic      [7:0]                 o_sample_count,
  output logic      [$clog2(DEPTH+1)-1:0] o_entries,
  output logic                            o_full
);
  if (DEPTH > 4096) begin : g_bad_depth
    $error("Scan list depth above the supported range.");
  end

  logic [15:0]             shift;
  logic [2:0]              sel_sync;
  logic [2:0]              dan_sync;
  logic [2:0]              bp_sync;
  logic                    sel_level;
  logic                    dan_level;
  logic                    bp_level;
  logic                    sel_rise;
  logic                    sel_fall;
  logic                    selected;
  logic [3:0]              sel_slot;
  logic                    cfg_wr;
  logic                    hardscan_control_reg_wr;
  logic                    fifo_wr;
  logic [10:0]             head_bits;
  slsw_pkg::slsw_entry_s   head;
  slsw_pkg::slsw_entry_s   incoming;

  // Link domain: only the shift register lives here, so nothing crosses on serial_clock.
  always_ff @(posedge link.serial_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      shift <= 16'h0000;
    end else begin
      shift <= {shift[14:0], link.serial_data_in};
    end
  end

  // Pin synchronisers; the third stage must agree with the second before a change counts.
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      sel_sync <= 3'h7;
      dan_sync <= 3'h7;
      bp_sync  <= 3'h7;
    end else begin
      sel_sync <= {sel_sync[1:0], link.slot0_select_n};
      dan_sync <= {dan_sync[1:0], link.data_addr_n};
      bp_sync  <= {bp_sync[1:0], i_backplane_reset_n};
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      sel_level <= 1'b1;
      dan_level <= 1'b1;
      bp_level  <= 1'b1;
    end else begin
      if (sel_sync[1] == sel_sync[2]) begin
        sel_level <= sel_sync[2];
      end
      if (dan_sync[1] == dan_sync[2]) begin
        dan_level <= dan_sync[2];
      end
      if (bp_sync[1] == bp_sync[2]) begin
        bp_level <= bp_sync[2];
      end
    end
  end

  assign sel_rise = (sel_sync[1] == sel_sync[2]) && sel_sync[2] && !sel_level;
  assign sel_fall = (sel_sync[1] == sel_sync[2]) && !sel_sync[2] && sel_level;

  // The shift word is read across domains only at select edges, when the host holds
  // serial_clock still, so the word is stable and the select line is its qualifier.
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      selected <= 1'b0;
      sel_slot <= 4'h0;
    end else if (sel_fall) begin
      selected <= 1'b0;
    end else if (sel_rise) begin
      selected <= (shift[`SLSW_SEL_CHAS_MSB:`SLSW_SEL_CHAS_LSB] == CHASSIS_ADDR);
      sel_slot <= shift[`SLSW_SEL_SLOT_MSB:`SLSW_SEL_SLOT_LSB];
    end
  end

  // Slot zero is the parking value and drives no select line.
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_module_select_n <= 16'hFFFF;
    end else if (selected && sel_slot != 4'h0) begin
      o_module_select_n <= ~(16'h0001 << sel_slot);
    end else begin
      o_module_select_n <= 16'hFFFF;
    end
  end

  // Commit on the falling select edge; every bit of the target changes in one cycle.
  assign cfg_wr  = sel_fall && selected && sel_slot == MODULE_SLOT && !dan_level;
  assign hardscan_control_reg_wr = sel_fall && selected && sel_slot == `SLSW_SLOT_HARDSCAN_CONTROL_REG && dan_level;
  assign fifo_wr = sel_fall && selected && sel_slot == `SLSW_SLOT_FIFO && dan_level;

  // All-zero configuration routes inputs straight to the outputs, bus off, scanning off.
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_config <= `SLSW_CONFIG_RESET;
    end else if (!bp_level) begin
      o_config <= `SLSW_CONFIG_RESET;
    end else if (cfg_wr) begin
      o_config <= shift;
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_hardscan_ctrl <= `SLSW_HARDSCAN_CONTROL_REG_RESET;
    end else if (hardscan_control_reg_wr) begin
      o_hardscan_ctrl <= shift[7:0];
    end
  end

  assign incoming = slsw_pkg::slsw_unpack(shift);

  slsw_scan_list #(
    .DEPTH (DEPTH),
    .WIDTH (11)
  ) u_scan_list (
    .i_clock   (i_clock),
    .i_nrst    (i_nrst),
    .i_clear   (!o_hardscan_ctrl[`SLSW_HARDSCAN_CONTROL_REG_RESET_N]),
    .i_rewind  (!o_hardscan_ctrl[`SLSW_HARDSCAN_CONTROL_REG_RETRANSMIT]),
    .i_advance (i_scan_advance),
    .i_write   (fifo_wr),
    .i_data    (incoming),
    .o_head    (head_bits),
    .o_entries (o_entries),
    .o_full    (o_full)
  );

  assign head = head_bits;

  // Slot and count are reported already incremented, as the scan engine uses them.
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_scan_slot    <= 5'h00;
      o_sample_count <= 8'h00;
    end else if (!o_hardscan_ctrl[`SLSW_HARDSCAN_CONTROL_REG_RESET_N]) begin
      o_scan_slot    <= 5'h00;
      o_sample_count <= 8'h00;
    end else if (!o_hardscan_ctrl[`SLSW_HARDSCAN_CONTROL_REG_LOAD_N]) begin
      o_scan_slot    <= {1'b0, head.slot} + 5'h01;
      o_sample_count <= {1'b0, head.count} + 8'h01;
    end
  end
endmodule

`default_nettype wire

// ===== slsw_host.sv
// Host board end: divides its clock into serial_clock and runs one complete register write.
// Assumes the device samples select edges with a few system clocks of latency.
`timescale 1ns/1ps
`default_nettype none
`include "slsw_regs.svh"

module slsw_host #(
  parameter int HALF = `SLSW_HALF_CYCLES,
  parameter int GAP  = `SLSW_GAP_CYCLES
) (
  // Clock and reset.
  input  wire logic        i_clock,
  input  wire logic        i_nrst,
  // Serial link to the device.
  slsw_if.host             link,
  // Command.
  input  wire logic        i_start,
  input  wire logic [15:0] i_slot_word,
  input  wire logic [15:0] i_data_word,
  input  wire logic        i_to_config,
  // Status.
  output logic             o_busy,
  output logic             o_done
);
  if (HALF < 1 || HALF > 65535 || GAP < 1 || GAP > 65535) begin : g_bad_timing
    $error("Serial half period and select gap must be 1 to 65535 cycles.");
  end

  slsw_pkg::slsw_host_state_e state;
  logic [15:0] timer;
  logic [15:0] word;
  logic [15:0] data_hold;
  logic        cfg;
  logic [1:0]  stage;
  logic [3:0]  bit_left;
  logic        sclk;
  logic        sdat;
  logic        sel_n;
  logic        dan;

  assign link.serial_clock   = sclk;
  assign link.serial_data_in = sdat;
  assign link.slot0_select_n = sel_n;
  assign link.data_addr_n    = dan;
  assign o_busy              = (state != slsw_pkg::SLSW_IDLE);

  // Stage 0 shifts the slot word, stage 1 the data word, stage 2 parks zero;
  // the select line toggles at the end of each, which gives high, low, high.
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      state     <= slsw_pkg::SLSW_IDLE;
      timer     <= 16'h0000;
      word      <= 16'h0000;
      data_hold <= 16'h0000;
      cfg       <= 1'b0;
      stage     <= 2'h0;
      bit_left  <= 4'h0;
      sclk      <= 1'b1;
      sdat      <= 1'b0;
      sel_n     <= 1'b1;
      dan       <= 1'b1;
      o_done    <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (state != slsw_pkg::SLSW_IDLE && timer != 16'h0000) begin
        timer <= timer - 16'h0001;
      end else begin
        unique case (state)
          slsw_pkg::SLSW_IDLE: begin
            if (i_start) begin
              word      <= i_slot_word;
              data_hold <= i_data_word;
              cfg       <= i_to_config;
              stage     <= 2'h0;
              sel_n     <= 1'b0;
              timer     <= 16'(GAP - 1);
              state     <= slsw_pkg::SLSW_SETUP;
            end
          end
          slsw_pkg::SLSW_SETUP: begin
            bit_left <= 4'hF;
            sdat     <= word[15];
            sclk     <= 1'b0;
            timer    <= 16'(HALF - 1);
            state    <= slsw_pkg::SLSW_LOW;
          end
          slsw_pkg::SLSW_LOW: begin
            sclk  <= 1'b1;
            timer <= 16'(HALF - 1);
            state <= slsw_pkg::SLSW_HIGH;
          end
          slsw_pkg::SLSW_HIGH: begin
            if (bit_left == 4'h0) begin
              sel_n <= ~sel_n;
              timer <= 16'(GAP - 1);
              state <= slsw_pkg::SLSW_TOGGLE;
            end else begin
              bit_left <= bit_left - 4'h1;
              word     <= {word[14:0], 1'b0};
              sdat     <= word[14];
              sclk     <= 1'b0;
              timer    <= 16'(HALF - 1);
              state    <= slsw_pkg::SLSW_LOW;
            end
          end
          slsw_pkg::SLSW_TOGGLE: begin
            timer <= 16'(GAP - 1);
            if (stage == 2'h0) begin
              stage <= 2'h1;
              word  <= data_hold;
              dan   <= ~cfg;
              state <= slsw_pkg::SLSW_SETUP;
            end else if (stage == 2'h1) begin
              stage <= 2'h2;
              word  <= 16'h0000;
              dan   <= 1'b1;
              state <= slsw_pkg::SLSW_SETUP;
            end else begin
              o_done <= 1'b1;
              state  <= slsw_pkg::SLSW_IDLE;
            end
          end
        endcase
      end
    end
  end
endmodule

`default_nettype wire

// ===== slsw_monitor.sv
// Concurrent checks on the serial lines between the host end and the chassis controller.
// Assumes the bench instantiates it beside the interface and hands on the host's half period.
`timescale 1ns/1ps
`default_nettype none

module slsw_monitor #(
  parameter int HALF = 2
) (
  // Clock and reset.
  input  wire logic i_clock,
  input  wire logic i_nrst,
  // Serial lines.
  input  wire logic serial_clock,
  input  wire logic serial_data_in,
  input  wire logic slot0_select_n,
  input  wire logic data_addr_n
);
  localparam int HALF_M1 = HALF - 1;

  // Phase 0 is idle, 1 the slot word, 2 the data word and 3 the parking word.
  logic [1:0] phase;
  logic [4:0] bits;
  logic       sel_q;
  logic       clk_q;

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      sel_q <= 1'b1;
      clk_q <= 1'b1;
    end else begin
      sel_q <= slot0_select_n;
      clk_q <= serial_clock;
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      phase <= 2'h0;
    end else if (slot0_select_n != sel_q) begin
      phase <= phase + 2'h1;
    end
  end

  // Counting rising edges between select edges shows a short or long word at the next select edge.
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      bits <= 5'h00;
    end else if (slot0_select_n != sel_q) begin
      bits <= 5'h00;
    end else if (serial_clock && !clk_q) begin
      bits <= bits + 5'h01;
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);

  select_edge_clock_a: assert property (
    $changed(slot0_select_n) |-> serial_clock) else $error("serial clock low at a select edge");
  clock_still_a: assert property (
    $changed(slot0_select_n) |=> $stable(serial_clock) [*6])
    else $error("serial clock moved next to a select edge");
  data_setup_a: assert property (
    $rose(serial_clock) |-> $stable(serial_data_in)) else $error("data moved with the rising clock");
  low_half_a: assert property (
    $fell(serial_clock) |-> ##HALF_M1 !serial_clock ##1 serial_clock)
    else $error("serial clock low time wrong");
  word_bits_a: assert property (
    ($changed(slot0_select_n) && phase != 2'h0) |-> bits == 5'h10)
    else $error("word was not sixteen bits");
  frame_idle_a: assert property (
    ($fell(slot0_select_n) && phase == 2'h0) |-> bits == 5'h00)
    else $error("serial clock ran between frames");
  addr_hold_a: assert property (
    $rose(serial_clock) |-> $stable(data_addr_n)) else $error("target line moved while shifting");
  park_zero_a: assert property (
    ($rose(serial_clock) && phase == 2'h3) |-> !serial_data_in)
    else $error("parking word not zero");
endmodule

`default_nettype wire

// ===== tb_scan_list_serial_write_port.sv
// Bench joining the host end and the chassis controller end across the serial interface.
// Assumes the package, header, interface and both design ends are compiled first.
`timescale 1ns/1ps
`default_nettype none

module tb_scan_list_serial_write_port;
  localparam int HALF  = 2;
  localparam int GAP   = 8;
  localparam int DEPTH = 4;

  logic        i_clock;
  logic        i_nrst;
  logic        start;
  logic [15:0] slot_word;
  logic [15:0] data_word;
  logic        to_config;
  logic        busy;
  logic        done;
  logic        bp_reset_n;
  logic        advance;
  logic [15:0] sel_n;
  logic [15:0] cfg;
  logic [7:0]  hardscan_control_reg;
  logic [4:0]  scan_slot;
  logic [7:0]  samples;
  logic [2:0]  entries;
  logic        full;
  logic        picked;
  int          failures;
  int          total_checks;

  slsw_if link ();

  slsw_host #(.HALF(HALF), .GAP(GAP)) slsw_host_inst (
    .i_clock(i_clock), .i_nrst(i_nrst), .link(link), .i_start(start),
    .i_slot_word(slot_word), .i_data_word(data_word), .i_to_config(to_config),
    .o_busy(busy), .o_done(done));

  slsw_device #(.CHASSIS_ADDR(4'h0), .MODULE_SLOT(4'h1), .DEPTH(DEPTH)) slsw_device_inst (
    .i_clock(i_clock), .i_nrst(i_nrst), .link(link), .i_backplane_reset_n(bp_reset_n),
    .i_scan_advance(advance), .o_module_select_n(sel_n), .o_config(cfg),
    .o_hardscan_ctrl(hardscan_control_reg), .o_scan_slot(scan_slot), .o_sample_count(samples),
    .o_entries(entries), .o_full(full));

  slsw_monitor #(.HALF(HALF)) slsw_monitor_inst (
    .i_clock(i_clock), .i_nrst(i_nrst), .serial_clock(link.serial_clock),
    .serial_data_in(link.serial_data_in), .slot0_select_n(link.slot0_select_n),
    .data_addr_n(link.data_addr_n));

  initial i_clock = 1'b0;
  always #2.5 i_clock = ~i_clock;

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] expected);
    total_checks++;
    if (seen !== expected) begin
      failures++;
      $display("unexpected at %0t seen %h expected %h", $time, seen, expected);
    end
  endtask

  // One complete write; picked tells whether module slot 1 was selected on the way.
  task automatic write_reg(input logic [15:0] sel, input logic [15:0] data, input logic to_cfg);
    int n;
    @(negedge i_clock);
    slot_word = sel;
    data_word = data;
    to_config = to_cfg;
    start = 1'b1;
    picked = 1'b0;
    @(negedge i_clock);
    start = 1'b0;
    check(16'(busy), 16'h0001);
    n = 0;
    while (done !== 1'b1 && n < 1000) begin
      picked = picked | (sel_n[1] === 1'b0);
      @(negedge i_clock);
      n++;
    end
    if (n >= 1000) begin
      failures++;
      complete_run();
    end
    repeat (4) @(negedge i_clock);
    check(16'(busy), 16'h0000);
  endtask

  // The head shows as slot field plus one and count field plus one.
  task automatic check_head(input logic [15:0] w);
    check(16'(scan_slot), 16'({1'b0, w[10:7]}) + 16'h0001);
    check(16'(samples), 16'({1'b0, w[6:0]}) + 16'h0001);
  endtask

  task automatic reset_values();
    check(sel_n, 16'hFFFF);
    check(cfg, 16'h0000);
    check(cfg, 16'h0000);
    check(16'(hardscan_control_reg), 16'h004C);
    check(16'(entries), 16'h0000);
  endtask

  task automatic config_writes();
    write_reg(16'h0001, 16'hA5C3, 1'b1);
    check(16'(picked), 16'h0001);
    check(cfg, 16'hA5C3);
    check(sel_n, 16'hFFFF);
    write_reg(16'h0001, 16'h5A3C, 1'b1);
    check(cfg, 16'h5A3C);
    write_reg(16'h0001, 16'h1111, 1'b0);
    check(cfg, 16'h5A3C);
    write_reg(16'h0011, 16'h1234, 1'b1);
    check(16'(picked), 16'h0000);
    check(cfg, 16'h5A3C);
  endtask

  task automatic backplane_reset();
    @(negedge i_clock);
    bp_reset_n = 1'b0;
    repeat (8) @(negedge i_clock);
    bp_reset_n = 1'b1;
    repeat (4) @(negedge i_clock);
    check(cfg, 16'h0000);
  endtask

  task automatic queue_scenario();
    logic [15:0] e [5];
    e = '{16'hFA85, 16'h007F, 16'h0780, 16'h0000, 16'h0123};
    write_reg(16'h000E, e[0], 1'b0);
    check(16'(entries), 16'h0001);
    check(16'(scan_slot), 16'h0000);
    write_reg(16'h000D, 16'h0048, 1'b0);
    check_head(e[0]);
    for (int i = 1; i < 5; i++) begin
      write_reg(16'h000E, e[i], 1'b0);
      check(16'(entries), 16'(i < DEPTH ? i + 1 : DEPTH));
    end
    check(16'(full), 16'h0001);
    check_head(e[0]);
    @(negedge i_clock);
    advance = 1'b1;
    @(negedge i_clock);
    advance = 1'b0;
    repeat (4) @(negedge i_clock);
    check_head(e[1]);
    write_reg(16'h000E, 16'h0000, 1'b0);
    check_head(e[1]);
    write_reg(16'h000D, 16'h0008, 1'b0);
    check_head(e[0]);
    check(16'(entries), 16'(DEPTH));
    write_reg(16'h000D, 16'h0048, 1'b0);
    // Two advances from the rewound position land on the third entry.
    advance = 1'b1;
    @(negedge i_clock);
    @(negedge i_clock);
    advance = 1'b0;
    repeat (4) @(negedge i_clock);
    check_head(e[2]);
    write_reg(16'h000D, 16'h0040, 1'b0);
    check(16'(entries), 16'h0000);
    check(16'(scan_slot), 16'h0000);
    write_reg(16'h000D, 16'h004C, 1'b0);
    check(16'(hardscan_control_reg), 16'h004C);
  endtask

  initial begin
    i_nrst = 1'b0;
    start = 1'b0;
    slot_word = 16'h0000;
    data_word = 16'h0000;
    to_config = 1'b0;
    bp_reset_n = 1'b1;
    advance = 1'b0;
    picked = 1'b0;
    failures = 0;
    total_checks = 0;
    repeat (2) @(negedge i_clock);
    i_nrst = 1'b1;
    @(negedge i_clock);
    reset_values();
    config_writes();
    backplane_reset();
    queue_scenario();
    complete_run();
  end
endmodule

`default_nettype wire
